/* include/icr_pkg.sv */
/*
 * Shared constants for the I2C control-register block: register address,
 * control bit positions, status bit positions and the wait points.
 * Assumes a byte-wide processor data path with bit-mask writes.
 */
package icr_pkg;
   localparam logic [15:0] ICR_CTRL_ADDR    = 16'hffa6;
   localparam logic [7:0]  ICR_CTRL_RESET   = 8'h00;
   localparam logic [7:0]  ICR_STATUS_RESET = 8'h00;

   // Control register bit positions
   localparam int ICR_B_ENABLE = 7;
   localparam int ICR_B_EXIT   = 6;
   localparam int ICR_B_WREL   = 5;
   localparam int ICR_B_SPIE   = 4;
   localparam int ICR_B_WTIM   = 3;
   localparam int ICR_B_ACKE   = 2;
   localparam int ICR_B_STT    = 1;
   localparam int ICR_B_SPT    = 0;

   // Bits that hold a stored value; the two command bits read back as zero
   localparam logic [7:0] ICR_CTRL_STORE_MASK = 8'h9f;

   // Status register bit positions
   localparam int ICR_S_MASTER = 7;
   localparam int ICR_S_EXT    = 6;
   localparam int ICR_S_MATCH  = 5;
   localparam int ICR_S_TRC    = 4;
   localparam int ICR_S_ACKD   = 3;
   localparam int ICR_S_STD    = 2;
   localparam int ICR_S_SPD    = 1;

   // Flags cleared by an exit from communication
   localparam logic [7:0] ICR_EXIT_CLR_MASK = 8'hfc;

   localparam int         ICR_CNT_W = 4;
   localparam logic [3:0] ICR_WAIT_EIGHTH = 4'h8;
   localparam logic [3:0] ICR_WAIT_NINTH  = 4'h9;
   localparam logic [3:0] ICR_CNT_FIRST   = 4'h1;
   localparam logic [3:0] ICR_CNT_ZERO    = 4'h0;

   typedef enum logic [1:0] {
      ICR_OFF,
      ICR_RUN,
      ICR_WAIT,
      ICR_STANDBY
   } icr_state_e;
endpackage

/* rtl/icr_sync.sv */
/*
 * Two-flop synchroniser for a group of level inputs.
 * Assumes the inputs are asynchronous to sys_clk; only the second stage is read.
 */
`timescale 1ns/10ps
`default_nettype none
module icr_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // Reset to high: an idle bus floats high, so no false edge at release
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= '1;
         sync_ff <= '1;
      end else begin
         meta_ff <= asyncIn;
         sync_ff <= meta_ff;
      end
   end

   assign syncOut = sync_ff;
endmodule
`default_nettype wire

/* rtl/icr_control.sv */
/*
 * I2C bus control register with enable, exit-from-communication and
 * wait-release handling, line wait control, start/stop detection and the
 * status flags that these commands touch.
 * Assumes the shift register, address compare and start/stop generators sit
 * outside and talk through the request, done and flag-set ports.
 */
`timescale 1ns/10ps
`default_nettype none
module icr_control
   import icr_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic [15:0] cpuAddr,
   input  wire logic        cpuWrite,
   input  wire logic [7:0]  cpuBitMask,
   input  wire logic [7:0]  cpuWrData,
   input  wire logic        cpuRead,
   output logic      [7:0]  cpuRdData,
   input  wire logic        sclIn,
   output logic             sclOut,
   output logic             sclOe,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe,
   input  wire logic        noiseFilterOn,
   input  wire logic        txDataBit,
   input  wire logic        setMasterState,
   input  wire logic        setTransmitState,
   input  wire logic        setAckDetected,
   input  wire logic        addressMatch,
   input  wire logic        extensionCode,
   input  wire logic        startRefused,
   input  wire logic        startDone,
   input  wire logic        stopDone,
   output logic             startRequest,
   output logic             stopRequest,
   output logic             stopIntEnable,
   output logic             transferInt,
   output logic             stopInt,
   output logic      [7:0]  busStatus,
   output logic             startRefusedFlag,
   output logic             busBusyFlag,
   output logic             clockLineLevel,
   output logic             dataLineLevel,
   output logic             standby,
   output logic             internalRun
);
   import icr_pkg::*;

   logic [7:0]           ctrl_ff;
   logic [7:0]           nxt_ctrl;
   logic [7:0]           status_ff;
   logic [7:0]           nxt_status;
   logic [7:0]           rdData_ff;
   icr_state_e           state_ff;
   icr_state_e           nxt_state;
   logic [ICR_CNT_W-1:0] bitCnt_ff;
   logic [ICR_CNT_W-1:0] nxt_bitCnt;
   logic                 sclPrev_ff;
   logic                 sdaPrev_ff;
   logic                 enablePrev_ff;
   logic                 afterStop_ff;
   logic                 afterStart_ff;
   logic                 busy_ff;
   logic                 refused_ff;
   logic                 clkLvl_ff;
   logic                 datLvl_ff;
   logic                 xferInt_ff;
   logic                 stopInt_ff;
   logic [1:0]           lineSync;

   icr_sync #(
      .WIDTH (2)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .asyncIn ({sclIn, sdaIn}),
      .syncOut (lineSync)
   );

   wire sclS = lineSync[1];
   wire sdaS = lineSync[0];

   // Register access decode
   wire addrHit   = (cpuAddr == ICR_CTRL_ADDR);
   wire wrHit     = cpuWrite & addrHit;
   wire [7:0] wrSet = cpuWrData & cpuBitMask;
   wire enabled   = ctrl_ff[ICR_B_ENABLE];
   // Commands act only on an enabled interface, judged before this write
   wire exitCmd   = wrHit & wrSet[ICR_B_EXIT] & enabled;
   wire wrelCmd   = wrHit & wrSet[ICR_B_WREL] & enabled;

   // Line events
   wire sclFall   = sclPrev_ff & ~sclS;
   wire enableRise = enabled & ~enablePrev_ff;
   // A low data line at enable looks like a falling edge through the filter
   wire spurStart = enableRise & sclS & ~sdaS & noiseFilterOn;
   wire startDet  = enabled & ((sclS & sclPrev_ff & sdaPrev_ff & ~sdaS) | spurStart);
   wire stopDet   = enabled & sclS & sclPrev_ff & ~sdaPrev_ff & sdaS;

   wire transmitting = status_ff[ICR_S_TRC];
   wire counting     = (state_ff == ICR_RUN);
   wire [ICR_CNT_W-1:0] cntInc = bitCnt_ff + ICR_CNT_FIRST;
   wire [ICR_CNT_W-1:0] fallCnt = (bitCnt_ff == ICR_WAIT_NINTH) ? ICR_CNT_FIRST : cntInc;
   wire [ICR_CNT_W-1:0] waitPoint = ctrl_ff[ICR_B_WTIM] ? ICR_WAIT_NINTH
                                                        : ICR_WAIT_EIGHTH;
   wire waitHit   = counting & sclFall & (fallCnt == waitPoint);
   wire waitFree  = (state_ff == ICR_WAIT) & wrelCmd;
   wire ninthFree = waitFree & (bitCnt_ff == ICR_WAIT_NINTH) & transmitting;

   // Master restart after a stop, or a hit on the address after a start
   wire rejoin = (afterStop_ff & ctrl_ff[ICR_B_STT])
               | (afterStart_ff & (addressMatch | extensionCode));

   // Control register next value
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wrHit) begin
         // Bit-mask merge serves both single-bit and byte writes
         nxt_ctrl = ((ctrl_ff & ~cpuBitMask) | wrSet) & ICR_CTRL_STORE_MASK;
      end
      if (enabled & startDone) begin
         nxt_ctrl[ICR_B_STT] = 1'b0;
      end
      if (enabled & stopDone) begin
         nxt_ctrl[ICR_B_SPT] = 1'b0;
      end
      if (exitCmd) begin
         nxt_ctrl[ICR_B_STT] = 1'b0;
         nxt_ctrl[ICR_B_SPT] = 1'b0;
      end
   end

   // Link state
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ICR_OFF: begin
            if (enabled) begin
               nxt_state = ICR_RUN;
            end
         end
         ICR_RUN: begin
            if (waitHit) begin
               nxt_state = ICR_WAIT;
            end
         end
         ICR_WAIT: begin
            if (waitFree) begin
               nxt_state = ICR_RUN;
            end
         end
         ICR_STANDBY: begin
            if (rejoin) begin
               nxt_state = ICR_RUN;
            end
         end
      endcase
      if (exitCmd) begin
         nxt_state = ICR_STANDBY;
      end
      if (!enabled) begin
         nxt_state = ICR_OFF;
      end
   end

   // Bit counter on falling clock edges, restarted by each start
   always_comb begin
      nxt_bitCnt = bitCnt_ff;
      if (startDet || !enabled || exitCmd) begin
         nxt_bitCnt = ICR_CNT_ZERO;
      end else if (counting && sclFall) begin
         nxt_bitCnt = fallCnt;
      end
   end

   // Status flags: a hardware set wins over a clear in the same cycle
   always_comb begin
      logic [7:0] setV;
      logic [7:0] clrV;
      setV = '0;
      clrV = '0;
      setV[ICR_S_MASTER] = setMasterState;
      setV[ICR_S_EXT]    = extensionCode;
      setV[ICR_S_MATCH]  = addressMatch;
      setV[ICR_S_TRC]    = setTransmitState;
      setV[ICR_S_ACKD]   = setAckDetected;
      setV[ICR_S_STD]    = startDet;
      setV[ICR_S_SPD]    = stopDet;
      clrV[ICR_S_STD]    = stopDet;
      clrV[ICR_S_SPD]    = startDet;
      clrV[ICR_S_TRC]    = ninthFree;
      if (exitCmd) begin
         clrV = clrV | ICR_EXIT_CLR_MASK;
      end
      nxt_status = (status_ff & ~clrV) | setV;
      if (!enabled) begin
         nxt_status = ICR_STATUS_RESET;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff   <= ICR_CTRL_RESET;
         status_ff <= ICR_STATUS_RESET;
         state_ff  <= ICR_OFF;
         bitCnt_ff <= ICR_CNT_ZERO;
      end else begin
         ctrl_ff   <= nxt_ctrl;
         status_ff <= nxt_status;
         state_ff  <= nxt_state;
         bitCnt_ff <= nxt_bitCnt;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sclPrev_ff    <= 1'b1;
         sdaPrev_ff    <= 1'b1;
         enablePrev_ff <= 1'b0;
      end else begin
         sclPrev_ff    <= sclS;
         sdaPrev_ff    <= sdaS;
         enablePrev_ff <= enabled;
      end
   end

   // Entry conditions for leaving standby are tracked only inside standby
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         afterStop_ff  <= 1'b0;
         afterStart_ff <= 1'b0;
      end else if (state_ff != ICR_STANDBY) begin
         afterStop_ff  <= 1'b0;
         afterStart_ff <= 1'b0;
      end else begin
         afterStop_ff  <= (afterStop_ff & ~startDet) | stopDet;
         afterStart_ff <= (afterStart_ff & ~stopDet) | startDet;
      end
   end

   // Bus-level flags, all held clear while disabled
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_ff    <= 1'b0;
         refused_ff <= 1'b0;
         clkLvl_ff  <= 1'b0;
         datLvl_ff  <= 1'b0;
      end else begin
         busy_ff    <= enabled & (startDet | (busy_ff & ~stopDet));
         refused_ff <= enabled & (startRefused | refused_ff);
         clkLvl_ff  <= enabled & sclS;
         datLvl_ff  <= enabled & sdaS;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         xferInt_ff <= 1'b0;
         stopInt_ff <= 1'b0;
      end else begin
         xferInt_ff <= waitHit;
         stopInt_ff <= stopDet & ctrl_ff[ICR_B_SPIE] & (state_ff != ICR_OFF);
      end
   end

   // Read path; command bits are never stored, so they read as zero
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdData_ff <= 8'h00;
      end else if (cpuRead) begin
         rdData_ff <= addrHit ? (ctrl_ff & ICR_CTRL_STORE_MASK) : 8'h00;
      end
   end

   // Line drive: clock held low only in a wait; standby drives nothing
   wire ackPhase = (bitCnt_ff == ICR_WAIT_EIGHTH) & ~transmitting & ctrl_ff[ICR_B_ACKE];
   wire txLow    = transmitting & ~txDataBit & (bitCnt_ff < ICR_WAIT_EIGHTH);
   wire driving  = (state_ff == ICR_RUN) | (state_ff == ICR_WAIT);

   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;
   assign sclOe  = (state_ff == ICR_WAIT);
   assign sdaOe  = driving & (ackPhase | txLow);

   assign cpuRdData        = rdData_ff;
   assign startRequest     = ctrl_ff[ICR_B_STT] & enabled;
   assign stopRequest      = ctrl_ff[ICR_B_SPT] & enabled;
   assign stopIntEnable    = ctrl_ff[ICR_B_SPIE] & enabled;
   assign transferInt      = xferInt_ff;
   assign stopInt          = stopInt_ff;
   assign busStatus        = status_ff;
   assign startRefusedFlag = refused_ff;
   assign busBusyFlag      = busy_ff;
   assign clockLineLevel   = clkLvl_ff;
   assign dataLineLevel    = datLvl_ff;
   assign standby          = (state_ff == ICR_STANDBY);
   assign internalRun      = (state_ff != ICR_OFF);
endmodule
`default_nettype wire

/* verification/icr_control_sva.sv */
/* Port checker for icr_control: enable gating, exit, wait hold and release.
   Assumes a single sys_clk domain with rst_b; bound to every icr_control. */
`timescale 1ns/10ps
`default_nettype none
module icr_control_chk
   import icr_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic [15:0] cpuAddr,
   input wire logic        cpuWrite,
   input wire logic [7:0]  cpuBitMask,
   input wire logic [7:0]  cpuWrData,
   input wire logic [7:0]  cpuRdData,
   input wire logic        sclOe,
   input wire logic        sdaOe,
   input wire logic        startRequest,
   input wire logic        stopRequest,
   input wire logic        transferInt,
   input wire logic [7:0]  busStatus,
   input wire logic        startRefusedFlag,
   input wire logic        standby,
   input wire logic        internalRun
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   wire ctlWr = cpuWrite && cpuAddr == ICR_CTRL_ADDR;
   // Exit only counts once the enable bit has stood a full cycle
   sequence s_exit;
      ctlWr && cpuBitMask == 8'h40 && cpuWrData[6] && internalRun && !$past(cpuWrite);
   endsequence
   property p_off_flags;
      !internalRun [*2] |-> busStatus == 8'h00 && !startRefusedFlag;
   endproperty
   a_off_flags: assert property (p_off_flags) else $error("flags set while off");
   property p_off_lines;
      !internalRun [*2] |-> !sclOe && !sdaOe;
   endproperty
   a_off_lines: assert property (p_off_lines) else $error("line pulled while off");
   property p_exit;
      s_exit |=> standby && !sclOe && !sdaOe;
   endproperty
   a_exit: assert property (p_exit) else $error("exit did not free the bus");
   property p_exit_clr;
      s_exit |=> !startRequest && !stopRequest && busStatus[7:2] == 6'h00;
   endproperty
   a_exit_clr: assert property (p_exit_clr) else $error("exit left flags set");
   property p_wait;
      transferInt |-> sclOe ##1 sclOe;
   endproperty
   a_wait: assert property (p_wait) else $error("wait point without clock hold");
   property p_wrel;
      ctlWr && cpuBitMask[5] && cpuWrData[5] && sclOe && internalRun |=> !sclOe;
   endproperty
   a_wrel: assert property (p_wrel) else $error("wait release kept clock low");
   property p_rd_zero;
      rst_b |-> cpuRdData[6:5] == 2'b00;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("command bit read as one");
   property p_enable;
      ctlWr && cpuBitMask[7] && cpuWrData[7] |-> ##2 internalRun;
   endproperty
   a_enable: assert property (p_enable) else $error("enable write not taken");
endmodule
bind icr_control icr_control_chk chk (.sys_clk, .rst_b, .cpuAddr, .cpuWrite, .cpuBitMask,
   .cpuWrData, .cpuRdData, .sclOe, .sdaOe, .startRequest, .stopRequest, .transferInt,
   .busStatus, .startRefusedFlag, .standby, .internalRun);
`default_nettype wire

/* verification/icr_bus_peer.sv */
/* Behavioural I2C master on the far side of the bus pins.
   Assumes open-drain wires with pull-ups built by the bench. */
`timescale 1ns/10ps
`default_nettype none
module icr_bus_peer (
   input  wire logic scl,
   output logic      sclPull,
   output logic      sdaPull
);
   int nBits = 0;
   // Both lines released while idle, so enabling sees a quiet bus
   initial {sclPull, sdaPull} = 2'b00;
   task automatic start();
      sdaPull = 1'b1;
      #32;
      sclPull = 1'b1;
      #32;
   endtask
   task automatic sendBit(input logic b);
      sdaPull = !b;
      #16;
      sclPull = 1'b0;
      // The device may stretch the low phase during its wait
      wait (scl === 1'b1);
      #32;
      sclPull = 1'b1;
      nBits++;
      #16;
   endtask
   task automatic stop();
      sdaPull = 1'b1;
      #16;
      sclPull = 1'b0;
      wait (scl === 1'b1);
      #32;
      sdaPull = 1'b0;
      #32;
   endtask
endmodule
`default_nettype wire

/* verification/icr_control_tb.sv */
/* Self-checking bench for icr_control: register access, enable gating,
   wait points, exit and standby. Assumes the bus peer and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) \
   begin \
      comparisons++; \
      if ((s) !== (e)) begin \
         badCount++; \
         $display("[ERR] %s expected %h seen %h", n, e, s); \
      end \
   end
module icr_control_tb;
   import icr_pkg::*;
   logic        sys_clk = 1'b0, rst_b = 1'b0, cpuWrite = 1'b0, cpuRead = 1'b0;
   logic        noiseFilterOn = 1'b0, sclOe, sdaOe, sclPull, sdaPull, standby;
   logic        startRequest, stopRequest, transferInt, startRefusedFlag, internalRun;
   logic        sclOut, sdaOut, busBusyFlag, clockLineLevel, dataLineLevel, stopInt, stopIntEnable;
   logic [15:0] cpuAddr = 16'h0000;
   logic [7:0]  cpuBitMask = 8'h00, cpuWrData = 8'h00, evIn = 8'h00;
   logic [7:0]  cpuRdData, busStatus, ctl, d, r, m;
   int          seed, badCount = 0, comparisons = 0, i, n, stopCnt = 0, cnt [2];
   // Pull-ups give a high level whenever neither side drives the pin
   wire         sclW = (sclOe ? sclOut : 1'b1) && !sclPull;
   wire         sdaW = (sdaOe ? sdaOut : 1'b1) && !sdaPull;
   always #2.5 sys_clk = !sys_clk;
   // Stop interrupts last one cycle, so they are tallied as they come
   always @(posedge sys_clk) begin
      if (stopInt === 1'b1) begin
         stopCnt <= stopCnt + 1;
      end
   end
   icr_control dut (
      .sys_clk, .rst_b, .cpuAddr, .cpuWrite, .cpuBitMask, .cpuWrData, .cpuRead,
      .cpuRdData, .sclIn(sclW), .sclOut, .sclOe, .sdaIn(sdaW), .sdaOut, .sdaOe,
      .noiseFilterOn, .txDataBit(1'b1), .setMasterState(evIn[7]), .extensionCode(evIn[6]),
      .addressMatch(evIn[5]), .setTransmitState(evIn[4]), .setAckDetected(evIn[3]),
      .startRefused(evIn[2]), .startDone(evIn[1]), .stopDone(evIn[0]), .startRequest,
      .stopRequest, .stopIntEnable, .transferInt, .stopInt, .busStatus,
      .startRefusedFlag, .busBusyFlag, .clockLineLevel, .dataLineLevel,
      .standby, .internalRun
   );
   icr_bus_peer peer (.scl(sclW), .sclPull, .sdaPull);
   function automatic logic [7:0] nxtCtl(input logic [7:0] o, k, v);
      logic [7:0] t;
      t = ((o & ~k) | (v & k)) & ICR_CTRL_STORE_MASK;
      if (o[7] && k[6] && v[6]) t[1:0] = 2'b00;
      return t;
   endfunction
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] k, input logic [7:0] v);
      tick();
      cpuAddr = a;
      cpuBitMask = k;
      cpuWrData = v;
      cpuWrite = 1'b1;
      tick();
      cpuWrite = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] q);
      tick();
      cpuAddr = a;
      cpuRead = 1'b1;
      tick();
      cpuRead = 1'b0;
      tick();
      q = cpuRdData;
   endtask
   task automatic pulse(input logic [7:0] e);
      tick();
      evIn = e;
      tick();
      evIn = 8'h00;
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, badCount);
      if (badCount == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // All scenarios need well under 30 us; twice that means a hang
   initial begin
      #60000;
      badCount++;
      results();
   end
   initial begin
      seed = 96;
      repeat (5) @(posedge sys_clk);
      #1;
      rst_b = 1'b1;
      rd(ICR_CTRL_ADDR, r);
      `CHK("ctl after reset", ICR_CTRL_RESET, r)
      wr(16'hffa7, 8'hff, 8'h9f);
      rd(16'hffa7, r);
      `CHK("unmapped read", 8'h00, r)
      `CHK("unmapped write", 1'b0, internalRun)
      $display("test registers done");
      for (i = 0; i < 16; i++) begin
         wr(ICR_CTRL_ADDR, 8'hff, 8'h00);
         d = $random(seed);
         ctl = nxtCtl(8'h00, 8'hff, d);
         wr(ICR_CTRL_ADDR, 8'hff, d);
         rd(ICR_CTRL_ADDR, r);
         `CHK("ctl byte", ctl, r)
         `CHK("exit ignored", 1'b0, standby)
         `CHK("line levels", {ctl[7], ctl[7]}, {clockLineLevel, dataLineLevel})
         `CHK("stop int en", ctl[7] & ctl[4], stopIntEnable)
         `CHK("start req", ctl[7] & ctl[1], startRequest)
         `CHK("stop req", ctl[7] & ctl[0], stopRequest)
         if (ctl[7]) begin
            d = $random(seed);
            pulse(d);
            ctl[1:0] = ctl[1:0] & ~d[1:0];
            `CHK("flags set", {d[7:3], 1'b0}, busStatus[7:2] & 6'h3e)
            n = $unsigned($random(seed)) % 3;
            m = (n == 2) ? 8'h40 : 8'h01 << n;
            d = $random(seed);
            wr(ICR_CTRL_ADDR, m, d);
            ctl = nxtCtl(ctl, m, d);
            rd(ICR_CTRL_ADDR, r);
            `CHK("ctl bit", ctl, r)
            if (m[6] && d[6]) begin
               `CHK("exit standby", 1'b1, standby)
               `CHK("exit flags", 6'h00, busStatus[7:2])
            end
         end
         wr(ICR_CTRL_ADDR, 8'h80, 8'h00);
         tick();
         `CHK("off flags", 9'h000, {busStatus, startRefusedFlag})
         `CHK("off bus flags", 3'b000, {busBusyFlag, clockLineLevel, dataLineLevel})
      end
      $display("test random access done");
      for (i = 0; i < 2; i++) begin
         wr(ICR_CTRL_ADDR, 8'hff, {3'b100, i[0], i[0], 3'b100});
         pulse(8'h10);
         peer.nBits = 0;
         peer.start();
         fork
            repeat (9) peer.sendBit(1'b1);
            begin
               n = 0;
               while (transferInt !== 1'b1 && n < 4000) begin
                  tick();
                  n++;
               end
               cnt[i] = peer.nBits;
               `CHK("wait reached", 1'b1, transferInt)
               repeat (20) tick();
               `CHK("scl held", 1'b0, sclW)
               `CHK("scl hold drive", 1'b1, sclOe)
               wr(ICR_CTRL_ADDR, 8'h20, 8'h20);
               tick();
               `CHK("wait freed", 1'b0, sclOe)
               `CHK("trc after free", !i[0], busStatus[4])
            end
         join
         peer.stop();
         rd(ICR_CTRL_ADDR, r);
         `CHK("cmd bits", 2'b00, r[6:5])
         wr(ICR_CTRL_ADDR, 8'hff, 8'h00);
      end
      `CHK("ninth vs eighth", cnt[0] + 1, cnt[1])
      `CHK("stop ints", 1, stopCnt)
      $display("test wait points done");
      wr(ICR_CTRL_ADDR, 8'hff, 8'h80);
      peer.start();
      repeat (3) peer.sendBit(1'b0);
      wr(ICR_CTRL_ADDR, 8'h02, 8'h02);
      wr(ICR_CTRL_ADDR, 8'h40, 8'h40);
      tick();
      `CHK("exit clears start req", 1'b0, startRequest)
      repeat (4) peer.sendBit(1'b0);
      `CHK("standby holds", 1'b1, standby)
      `CHK("lines free", 2'b00, {sclOe, sdaOe})
      peer.stop();
      peer.start();
      pulse(8'h20);
      tick();
      `CHK("standby left", 1'b0, standby)
      peer.stop();
      // Second way out: a stop seen in standby, then a master restart
      wr(ICR_CTRL_ADDR, 8'h40, 8'h40);
      peer.start();
      peer.stop();
      `CHK("standby after stop", 1'b1, standby)
      wr(ICR_CTRL_ADDR, 8'h02, 8'h02);
      tick();
      `CHK("restart leaves standby", 1'b0, standby)
      wr(ICR_CTRL_ADDR, 8'hff, 8'h00);
      $display("test exit done");
      peer.sdaPull = 1'b1;
      noiseFilterOn = 1'b1;
      repeat (4) tick();
      wr(ICR_CTRL_ADDR, 8'h80, 8'h80);
      repeat (2) tick();
      `CHK("spurious start", 1'b1, busStatus[2])
      `CHK("spurious busy", 1'b1, busBusyFlag)
      wr(ICR_CTRL_ADDR, 8'h40, 8'h40);
      tick();
      `CHK("start flag cleared", 1'b0, busStatus[2])
      `CHK("spurious standby", 1'b1, standby)
      peer.sdaPull = 1'b0;
      wr(ICR_CTRL_ADDR, 8'hff, 8'h00);
      $display("test spurious start done");
      wr(ICR_CTRL_ADDR, 8'hff, 8'h9f);
      rst_b = 1'b0;
      tick();
      rst_b = 1'b1;
      rd(ICR_CTRL_ADDR, r);
      `CHK("ctl after mid reset", ICR_CTRL_RESET, r)
      `CHK("off after mid reset", 1'b0, internalRun)
      `CHK("req after mid reset", 2'b00, {startRequest, stopRequest})
      $display("test mid-run reset done");
      results();
   end
endmodule
`default_nettype wire
